// [hdl/bst_tap.sv]
// Boundary-scan test access port with config-load and analyzer access
`timescale 1ns/1ps
`default_nettype none

// How it works
// - A standard sixteen-state controller steers instruction and data scan.
// - While configuration runs, pin test instructions act as bypass.
// - Configuration words shifted in on the port are handed to the core.
// - Probe values of running logic can be read out through the port.
// - Sample captures pins and preloads the update cells without effect.
// - External test drives update cells to pins and captures pin levels.
// - Bypass puts one stage between data in and data out.
// - User code puts a 32-stage code register on the scan path.
// - Identification puts the id register on the scan path.
// - The config-load instruction accepts data from any host.
// - The analyzer instruction captures the latest probe snapshot.
module bst_tap #(
  parameter int unsigned PIN_N     = 8,
  parameter int unsigned CFG_W     = 32,
  parameter int unsigned ANA_W     = 16,
  parameter logic [31:0] ID_CODE   = 32'h1234_5001, // Arbitrary value
  parameter logic [31:0] USER_CODE = 32'h0000_0000
) (
  // System clock domain
  input  wire logic             clock,
  input  wire logic             sys_rst,
  // Test port, on its own clock
  input  wire logic             tck,
  input  wire logic             test_rst_n,
  input  wire logic             tms,
  input  wire logic             tdi,
  output var  logic             tdo,
  output var  logic             tdo_oe_n,
  // Device pins and core side
  input  wire logic [PIN_N-1:0] pin_in,
  input  wire logic [PIN_N-1:0] core_out,
  output var  logic [PIN_N-1:0] pin_out,
  // Configuration hand-off, system domain
  input  wire logic             cfg_active,
  output var  logic [CFG_W-1:0] cfg_word,
  output var  logic             cfg_valid,
  // Analyzer probes, system domain
  input  wire logic [ANA_W-1:0] probe
);

  import bst_pkg::*;

  // Data register widths
  localparam int unsigned BSR_W = 2 * PIN_N;
  localparam int unsigned W1    = (BSR_W > 32) ? BSR_W : 32;
  localparam int unsigned W2    = (CFG_W > W1) ? CFG_W : W1;
  localparam int unsigned DR_W  = (ANA_W > W2) ? ANA_W : W2;
  localparam int unsigned CW    = (CFG_W > 1) ? $clog2(CFG_W) : 1;
  localparam logic [CW-1:0] CNT_LAST = CW'(CFG_W - 1);
  localparam int unsigned TS_W  = BSR_W + 2;

  typedef struct packed {
    bst_tap_t         st;
    logic [IR_W-1:0]  ir_sh;
    bst_ins_t         sel;
    logic [DR_W-1:0]  dr_sh;
    logic [PIN_N-1:0] upd;
    logic [CW-1:0]    cnt;
    logic [CFG_W-1:0] cfg_hold;
    logic             cfg_tog;
    logic [ANA_W-1:0] ana_hold;
    logic             ana_ack;
  } bst_tck_t;

  typedef struct packed {
    logic             cfg_seen;
    logic [CFG_W-1:0] cfg_word;
    logic             cfg_valid;
    logic             ana_req;
    logic [ANA_W-1:0] ana_snap;
  } bst_sys_t;
  bst_tck_t t_q;
  bst_tck_t t_d;
  bst_sys_t s_q;
  bst_sys_t s_d;
  logic [TS_W-1:0]  ts_in;
  logic [TS_W-1:0]  ts_out;
  logic [1:0]       ss_out;
  logic [BSR_W-1:0] cap_s;
  logic             busy_s;
  logic             req_s;
  logic             tog_s;
  logic             ack_s;
  logic             test_rst;
  bst_ins_t         eff;
  logic             tdo_q;
  logic             oe_n_q;

  // Controller transition on each test clock
  function automatic bst_tap_t tap_next(bst_tap_t s, logic m);
    unique case (s)
      ST_RESET:  return m ? ST_RESET  : ST_IDLE;
      ST_IDLE:   return m ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: return m ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: return m ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR:  return m ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: return m ? ST_UP_DR  : ST_PA_DR;
      ST_PA_DR:  return m ? ST_EX2_DR : ST_PA_DR;
      ST_EX2_DR: return m ? ST_UP_DR  : ST_SH_DR;
      ST_UP_DR:  return m ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: return m ? ST_RESET  : ST_CAP_IR;
      ST_CAP_IR: return m ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR:  return m ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: return m ? ST_UP_IR  : ST_PA_IR;
      ST_PA_IR:  return m ? ST_EX2_IR : ST_PA_IR;
      ST_EX2_IR: return m ? ST_UP_IR  : ST_SH_IR;
      ST_UP_IR:  return m ? ST_SEL_DR : ST_IDLE;
    endcase
  endfunction : tap_next

  // Scan length of the selected data register
  function automatic int unsigned dr_len(bst_ins_t s);
    unique case (s)
      INS_IDCODE, INS_USER:   return 32;
      INS_EXTEST, INS_SAMPLE: return BSR_W;
      INS_CFG:                return CFG_W;
      INS_ANA:                return ANA_W;
      INS_BYPASS:             return 1;
    endcase
  endfunction : dr_len

  assign test_rst = !test_rst_n;

  // Pins, core values, busy level and analyzer request into the test clock
  assign ts_in = {cfg_active, s_q.ana_req, core_out, pin_in};

  bst_sync #(.W(TS_W)) u_sync_tck (
    .clk (tck),
    .rst (test_rst),
    .d   (ts_in),
    .q   (ts_out)
  );

  assign cap_s  = ts_out[BSR_W-1:0];
  assign req_s  = ts_out[BSR_W];
  assign busy_s = ts_out[BSR_W+1];

  // Word toggle and analyzer acknowledge into the system clock
  bst_sync #(.W(2)) u_sync_sys (
    .clk (clock),
    .rst (sys_rst),
    .d   ({t_q.ana_ack, t_q.cfg_tog}),
    .q   (ss_out)
  );

  assign tog_s = ss_out[0];
  assign ack_s = ss_out[1];

  // pin tests blocked
  // Pin test instructions fall back to bypass during configuration
  always_comb
  begin
    eff = t_q.sel;
    if (busy_s && (t_q.sel == INS_EXTEST || t_q.sel == INS_SAMPLE))
      eff = INS_BYPASS;
  end

  // Test clock domain next state
  always_comb
  begin
    t_d = t_q;
    t_d.st = tap_next(t_q.st, tms);
    if (req_s != t_q.ana_ack)
    begin
      t_d.ana_hold = s_q.ana_snap;
      t_d.ana_ack  = req_s;
    end
    unique case (t_q.st)
      ST_RESET:
      begin
        t_d.ir_sh = CODE_IDCODE;
        t_d.sel   = INS_IDCODE;
      end
      ST_CAP_IR: t_d.ir_sh = IR_CAPTURE;
      ST_SH_IR:  t_d.ir_sh = {tdi, t_q.ir_sh[IR_W-1:1]};
      ST_UP_IR:  t_d.sel = bst_decode(t_q.ir_sh);
      ST_CAP_DR:
      begin
        t_d.dr_sh = '0;
        t_d.cnt   = '0;
        unique case (eff)
          INS_IDCODE: t_d.dr_sh[31:0] = ID_CODE;
          INS_USER:   t_d.dr_sh[31:0] = USER_CODE;
          INS_EXTEST, INS_SAMPLE:
            t_d.dr_sh[BSR_W-1:0] = cap_s;
          INS_ANA:    t_d.dr_sh[ANA_W-1:0] = t_q.ana_hold;
          INS_CFG, INS_BYPASS: t_d.dr_sh = '0;
        endcase
      end
      ST_SH_DR:
      begin
        t_d.dr_sh = t_q.dr_sh >> 1;
        t_d.dr_sh[dr_len(eff)-1] = tdi;
        if (eff == INS_CFG)
        begin
          t_d.cnt = t_q.cnt + CW'(1);
          if (t_q.cnt == CNT_LAST)
          begin
            t_d.cnt      = '0;
            t_d.cfg_hold = t_d.dr_sh[CFG_W-1:0];
            t_d.cfg_tog  = !t_q.cfg_tog;
          end
        end
      end
      ST_UP_DR:
        if (eff == INS_EXTEST || eff == INS_SAMPLE)
          t_d.upd = t_q.dr_sh[BSR_W-1:PIN_N];
      default: ;
    endcase
    if (test_rst)
    begin
      t_d       = '0;
      t_d.st    = ST_RESET;
      t_d.ir_sh = CODE_IDCODE;
      t_d.sel   = INS_IDCODE;
    end
  end

  // Test clock domain state register
  always_ff @(posedge tck)
  begin
    t_q <= t_d;
  end

  // Serial output changes on the falling test clock edge
  always_ff @(negedge tck)
  begin
    if (test_rst)
    begin
      tdo_q  <= 1'b0;
      oe_n_q <= 1'b1;
    end
    else
    begin
      tdo_q  <= (t_q.st == ST_SH_IR) ? t_q.ir_sh[0] : t_q.dr_sh[0];
      oe_n_q <= !(t_q.st == ST_SH_IR || t_q.st == ST_SH_DR);
    end
  end

  assign tdo      = tdo_q;
  assign tdo_oe_n = oe_n_q;

  // pins follow core except under external test
  assign pin_out = (eff == INS_EXTEST) ? t_q.upd : core_out;

  // System domain next state
  always_comb
  begin
    s_d           = s_q;
    s_d.cfg_valid = 1'b0;
    if (tog_s != s_q.cfg_seen)
    begin
      s_d.cfg_seen  = tog_s;
      s_d.cfg_word  = t_q.cfg_hold;
      s_d.cfg_valid = 1'b1;
    end
    // publish a fresh snapshot once taken
    if (ack_s == s_q.ana_req)
    begin
      s_d.ana_snap = probe;
      s_d.ana_req  = !s_q.ana_req;
    end
    if (sys_rst)
    begin
      s_d = '0;
    end
  end

  // System domain state register
  always_ff @(posedge clock)
  begin
    s_q <= s_d;
  end

  assign cfg_word  = s_q.cfg_word;
  assign cfg_valid = s_q.cfg_valid;

  tms_reset_a: assert property (
    @(posedge tck) disable iff (test_rst)
    tms [*5] |=> t_q.st == ST_RESET)
    else $error("five tms ones did not reset");
  ir_capture_a: assert property (
    @(posedge tck) disable iff (test_rst)
    t_q.st == ST_CAP_IR |=> t_q.ir_sh[1:0] == 2'b01)
    else $error("instruction capture pattern wrong");
  bypass_stage_a: assert property (
    @(posedge tck) disable iff (test_rst)
    (t_q.st == ST_SH_DR && eff == INS_BYPASS)
      |=> t_q.dr_sh[0] == $past(tdi))
    else $error("bypass is not one stage");
  unassigned_bypass_a: assert property (
    @(posedge tck) disable iff (test_rst)
    (t_q.st == ST_UP_IR && t_q.ir_sh == 4'h3) |=> t_q.sel == INS_BYPASS)
    else $error("unassigned code not bypass");
  idcode_load_a: assert property (
    @(posedge tck) disable iff (test_rst)
    (t_q.st == ST_CAP_DR && eff == INS_IDCODE)
      |=> t_q.dr_sh[31:0] == ID_CODE)
    else $error("id code not captured");
  usercode_load_a: assert property (
    @(posedge tck) disable iff (test_rst)
    (t_q.st == ST_CAP_DR && eff == INS_USER)
      |=> t_q.dr_sh[31:0] == USER_CODE)
    else $error("user code not captured");
  extest_drive_a: assert property (
    @(posedge tck) disable iff (test_rst)
    (t_q.st == ST_UP_DR && eff == INS_EXTEST)
      |=> busy_s || pin_out == $past(t_q.dr_sh[BSR_W-1:PIN_N]))
    else $error("external test not driving pins");
  sample_quiet_a: assert property (
    @(posedge tck) disable iff (test_rst)
    t_q.sel == INS_SAMPLE |-> pin_out == core_out)
    else $error("sample disturbed pins");
  config_block_a: assert property (
    @(posedge tck) disable iff (test_rst)
    (busy_s && t_q.st == ST_CAP_DR && t_q.sel == INS_EXTEST)
      |=> t_q.dr_sh == '0)
    else $error("pin test ran during configuration");
  cfg_toggle_a: assert property (
    @(posedge tck) disable iff (test_rst)
    (t_q.st == ST_SH_DR && eff == INS_CFG && t_q.cnt == CNT_LAST)
      |=> t_q.cfg_tog != $past(t_q.cfg_tog))
    else $error("config word not handed off");
  cfg_pulse_a: assert property (
    @(posedge clock) disable iff (sys_rst)
    cfg_valid |=> !cfg_valid)
    else $error("config strobe longer than one cycle");
  ana_capture_a: assert property (
    @(posedge tck) disable iff (test_rst)
    (t_q.st == ST_CAP_DR && eff == INS_ANA)
      |=> t_q.dr_sh[ANA_W-1:0] == $past(t_q.ana_hold))
    else $error("analyzer snapshot not captured");

endmodule : bst_tap

`default_nettype wire

// [shared/bst_pkg.sv]
// Shared types and constants for the boundary-scan test access port
package bst_pkg;

  // Instruction register width and capture pattern
  localparam int unsigned     IR_W       = 4;
  localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;

  // Instruction codes
  localparam logic [IR_W-1:0] CODE_EXTEST = 4'h0;
  localparam logic [IR_W-1:0] CODE_SAMPLE = 4'h5;
  localparam logic [IR_W-1:0] CODE_IDCODE = 4'h6;
  localparam logic [IR_W-1:0] CODE_USER   = 4'h7;
  localparam logic [IR_W-1:0] CODE_CFG    = 4'h8;
  localparam logic [IR_W-1:0] CODE_ANA    = 4'ha;
  localparam logic [IR_W-1:0] CODE_BYPASS = 4'hf;

  // Test port controller states
  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE,
    ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PA_DR, ST_EX2_DR, ST_UP_DR,
    ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PA_IR, ST_EX2_IR, ST_UP_IR
  } bst_tap_t;

  // Decoded instructions
  typedef enum logic [2:0] {
    INS_IDCODE, INS_EXTEST, INS_SAMPLE, INS_USER,
    INS_CFG, INS_ANA, INS_BYPASS
  } bst_ins_t;

  // Map an instruction code to its data register selection
  function automatic bst_ins_t bst_decode(logic [IR_W-1:0] code);
    unique case (code)
      CODE_EXTEST: return INS_EXTEST;
      CODE_SAMPLE: return INS_SAMPLE;
      CODE_IDCODE: return INS_IDCODE;
      CODE_USER:   return INS_USER;
      CODE_CFG:    return INS_CFG;
      CODE_ANA:    return INS_ANA;
      default:     return INS_BYPASS;
    endcase
  endfunction : bst_decode

endpackage : bst_pkg

// [hdl/bst_sync.sv]
// Two-stage level synchroniser for a bus of independent bits
`timescale 1ns/1ps
`default_nettype none

module bst_sync #(
  parameter int unsigned W = 1
) (
  // Destination clock and synchronous reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Level in and synchronised level out
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } bst_sync_t;

  bst_sync_t r_q;
  bst_sync_t r_d;

  // First stage feeds only the second stage
  always_comb
  begin
    r_d.s1 = d;
    r_d.s2 = r_q.s1;
    if (rst)
    begin
      r_d = '0;
    end
  end

  // State register
  always_ff @(posedge clk)
  begin
    r_q <= r_d;
  end

  assign q = r_q.s2;

endmodule : bst_sync

`default_nettype wire

// [test/bst_host.sv]
// Test host model that drives the scan port in framed bursts
`timescale 1ns/1ps
`default_nettype none

module bst_host (
  // Scan port driven by the host
  output var  logic tck,
  output var  logic tms,
  output var  logic tdi,
  output var  logic test_rst_n,
  // Scan port returned by the device
  input  wire logic tdo,
  input  wire logic tdo_oe_n
);
  logic oe_bad;
  logic tdo_s;
  logic oe_s;

  // Idle levels; the test clock stands still between frames
  initial
  begin
    tck        = 1'b0;
    tms        = 1'b1;
    tdi        = 1'b0;
    test_rst_n = 1'b0;
    oe_bad     = 1'b0;
  end

  // One 15 ns period; inputs move while low, tdo taken just before the rise
  task automatic tick(input logic m, input logic d);
    tms = m;
    tdi = d;
    #7.5;
    tdo_s = tdo;
    oe_s  = tdo_oe_n;
    tck = 1'b1;
    #7.5;
    tck = 1'b0;
  endtask : tick

  // Port reset over four rising edges, then park in idle
  task automatic port_reset();
    test_rst_n = 1'b0;
    repeat (4) tick(1'b1, ~tdi);
    test_rst_n = 1'b1;
    tick(1'b0, ~tdi);
  endtask : port_reset

  // scans are framed, tdo read before each rise
  task automatic shift(input int n, input logic [71:0] d,
                       output logic [71:0] q);
    q = '0;
    for (int k = 0; k < n; k++)
    begin
      tick(k == n - 1, d[k]);
      q[k] = tdo_s;
      if (oe_s !== 1'b0)
        oe_bad = 1'b1;
    end
    tick(1'b1, ~tdi); // Update
    tick(1'b0, ~tdi); // Back to idle
  endtask : shift

  // instruction load used also for config-load
  task automatic ir_scan(input logic [3:0] c, output logic [71:0] q);
    tick(1'b1, ~tdi);
    tick(1'b1, ~tdi);
    tick(1'b0, ~tdi);
    tick(1'b0, ~tdi);
    shift(4, {68'h0, c}, q);
  endtask : ir_scan

  // Data register scan from idle
  task automatic dr_scan(input int n, input logic [71:0] d,
                         output logic [71:0] q);
    tick(1'b1, ~tdi);
    tick(1'b0, ~tdi);
    tick(1'b0, ~tdi);
    shift(n, d, q);
  endtask : dr_scan
endmodule : bst_host

`default_nettype wire

// [test/bst_tap_tb.sv]
// Self-checking bench for the boundary-scan test port
`timescale 1ns/1ps
`default_nettype none

module bst_tap_tb;
  import bst_pkg::*;

  typedef struct packed {
    logic [3:0]  code;
    logic [7:0]  n;
    logic [71:0] din;
    logic [71:0] dout;
    logic [7:0]  pin;
    logic        see;
  } bst_row_t;

  localparam logic [31:0] TB_ID   = 32'h2468_ace1; // Arbitrary value
  localparam logic [31:0] TB_USER = 32'hfeed_0b0e;
  localparam logic [7:0]  CORE    = 8'h96;
  localparam logic [7:0]  PIN     = 8'h71;
  localparam logic [15:0] PROBE   = 16'hbeef;
  localparam logic [71:0] CFG_IN  = {8'hff, 32'h89ab_cdef, 32'h0123_4567};

  // Instruction, scan length, data in, data out, pins after
  localparam bst_row_t ROWS [10] = '{
    '{CODE_IDCODE, 8'd32, 72'h0, {40'h0, TB_ID}, CORE, 1'b1},
    '{CODE_USER, 8'd32, 72'h0, {40'h0, TB_USER}, CORE, 1'b1},
    '{CODE_BYPASS, 8'd8, 72'hb5, 72'h6a, CORE, 1'b1},
    '{4'h3, 8'd8, 72'h5a, 72'hb4, CORE, 1'b1},
    '{4'hc, 8'd8, 72'h0f, 72'h1e, CORE, 1'b1},
    '{CODE_SAMPLE, 8'd16, 72'h3c00, {56'h0, CORE, PIN}, CORE, 1'b1},
    '{CODE_EXTEST, 8'd16, 72'hc300, {56'h0, CORE, PIN}, 8'hc3, 1'b1},
    '{CODE_ANA, 8'd16, 72'h0, {56'h0, PROBE}, CORE, 1'b1},
    '{CODE_CFG, 8'd72, CFG_IN, 72'h0, CORE, 1'b0},
    '{CODE_BYPASS, 8'd1, 72'h1, 72'h0, CORE, 1'b1}
  };

  logic        clock;
  logic        sys_rst;
  logic        tck;
  logic        test_rst_n;
  logic        tms;
  logic        tdi;
  logic        tdo;
  logic        tdo_oe_n;
  logic [7:0]  pin_in;
  logic [7:0]  core_out;
  logic [7:0]  pin_out;
  logic        cfg_active;
  logic [31:0] cfg_word;
  logic        cfg_valid;
  logic [15:0] probe;
  logic [71:0] q;
  logic [31:0] words [$];
  int          fail_count = 0;
  int          check_count = 0;

  bst_tap #(
    .ID_CODE   (TB_ID),
    .USER_CODE (TB_USER)
  ) u_bst_tap (
    .clock      (clock),
    .sys_rst    (sys_rst),
    .tck        (tck),
    .test_rst_n (test_rst_n),
    .tms        (tms),
    .tdi        (tdi),
    .tdo        (tdo),
    .tdo_oe_n   (tdo_oe_n),
    .pin_in     (pin_in),
    .core_out   (core_out),
    .pin_out    (pin_out),
    .cfg_active (cfg_active),
    .cfg_word   (cfg_word),
    .cfg_valid  (cfg_valid),
    .probe      (probe)
  );

  bst_host u_bst_host (
    .tck        (tck),
    .tms        (tms),
    .tdi        (tdi),
    .test_rst_n (test_rst_n),
    .tdo        (tdo),
    .tdo_oe_n   (tdo_oe_n)
  );

  // System clock, 40 ns period
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // Gather every handed-off configuration word
  always @(posedge clock)
    if (cfg_valid === 1'b1)
      words.push_back(cfg_word);

  // Compare and count
  task automatic chk(input logic [71:0] got, input logic [71:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Verdict and end of run
  task automatic tally_and_finish();
    if (fail_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish

  // Cut a hang short
  initial
  begin
    #300us;
    fail_count++;
    tally_and_finish();
  end

  // Main sequence
  initial
  begin
    sys_rst    = 1'b1;
    pin_in     = PIN;
    core_out   = CORE;
    cfg_active = 1'b0;
    probe      = PROBE;
    fork
      begin
        repeat (8) @(posedge clock);
        sys_rst <= 1'b0;
      end
      u_bst_host.port_reset();
    join
    foreach (ROWS[i])
    begin
      u_bst_host.ir_scan(ROWS[i].code, q);
      chk(q, {68'h0, IR_CAPTURE});
      u_bst_host.dr_scan(int'(ROWS[i].n), ROWS[i].din, q);
      if (ROWS[i].see)
        chk(q, ROWS[i].dout);
      #1;
      chk({64'h0, pin_out}, {64'h0, ROWS[i].pin});
    end
    // Two whole words back to back, trailing partial word dropped
    repeat (10) @(posedge clock);
    chk(72'(words.size()), 72'd2);
    chk({40'h0, words[0]}, {40'h0, CFG_IN[31:0]});
    chk({40'h0, words[1]}, {40'h0, CFG_IN[63:32]});
    // Pin test during configuration acts as bypass
    cfg_active <= 1'b1;
    repeat (3) @(posedge clock);
    u_bst_host.ir_scan(CODE_EXTEST, q);
    u_bst_host.dr_scan(8, 72'hb5, q);
    chk(q, 72'h6a);
    #1;
    chk({64'h0, pin_out}, {64'h0, CORE});
    @(posedge clock);
    cfg_active <= 1'b0;
    // Pin test usable again after configuration, then cleared by port reset
    u_bst_host.ir_scan(CODE_EXTEST, q);
    #1;
    chk({64'h0, pin_out}, {64'h0, 8'hc3});
    u_bst_host.port_reset();
    #1;
    chk({64'h0, pin_out}, {64'h0, CORE});
    // Five mode-select ones return to reset and identification
    repeat (5) u_bst_host.tick(1'b1, 1'b0);
    u_bst_host.tick(1'b0, 1'b1);
    u_bst_host.dr_scan(32, 72'h0, q);
    chk(q, {40'h0, TB_ID});
    chk({71'h0, u_bst_host.oe_bad}, 72'h0);
    tally_and_finish();
  end
endmodule : bst_tap_tb

`default_nettype wire
